// >>> dv/nvc_core_model.sv
// Core model driving the data-space port of nvc_ctrl.
// Assumes the bench calls xfer and that ack is a one-cycle pulse.
`default_nettype none
module nvc_core_model
  import nvc_pkg::*;
(
  input  wire logic     clk_i,
  input  wire nvc_rsp_t rsp_i,
  output var nvc_req_t  req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle port from time zero.
  initial req_o = '0;
  // Held until ack is sampled, then released with inverted lines, so a
  // design that reads a stale request sees a changed value.
  task automatic xfer(input logic w, wd, input logic [15:0] a, input logic [7:0] d,
                      output int n);
    n = 0;
    @(posedge clk_i);
    req_o <= '{valid: 1'b1, write: w, word: wd, addr: a, wdata: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp_i.ack !== 1'b1 && n < 64);
    req_o <= '{valid: 1'b0, write: ~w, word: ~wd, addr: ~a, wdata: ~d};
  endtask
endmodule // nvc_core_model
`default_nettype wire

// >>> dv/nvc_ctrl_chk.sv
// Port assertions for nvc_ctrl, bound at the foot of this file.
// Assumes one clock domain with its asynchronous reset.
`default_nettype none
module nvc_ctrl_chk
  import nvc_pkg::*;
#(parameter int unsigned PROG_CYCLES_P = 20) (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire nvc_req_t    req_i,
  input wire nvc_rsp_t    rsp_o,
  input wire logic        ext_irq_line_four_i,
  input wire logic        irq_line_four_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ien_q;
  logic ien_d;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Mirror of the irq enable, so the pin path is judged only while it is off.
  always_comb begin
    ien_d = ien_q;
    if (pready_o && pwrite_i && pstrb_i[0] && paddr_i == CTRL_ADDR) begin
      ien_d = pwdata_i[BIT_IRQ_EN];
    end
  end
  // Register of the mirror.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ien_q <= 1'b0;
    end else begin
      ien_q <= ien_d;
    end
  end
  ////////////////////////////////////////////////////////////
  // An access phase still waiting, and a finished control read.
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_ctrl_rd;
    pready_o && !pwrite_i && paddr_i == CTRL_ADDR;
  endsequence
  a_apb_one_wait: assert property (s_access |=> pready_o)
    else $error("ready late");
  a_apb_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  a_ctrl_top_zero: assert property (s_ctrl_rd |-> prdata_o[31:7] == 25'h0)
    else $error("bit 7 set");
  a_apb_unmapped_err: assert property (
    pready_o && paddr_i != CTRL_ADDR |-> pslverr_o && prdata_o == 32'h0) else $error("no error");
  a_data_ack_pulse: assert property (rsp_o.ack |=> !rsp_o.ack)
    else $error("ack held");
  a_write_no_data: assert property (rsp_o.ack && req_i.write |-> !rsp_o.rvalid)
    else $error("write rvalid");
  a_unmapped_data: assert property (
    rsp_o.ack && req_i.addr > RAM_LAST |-> !rsp_o.rvalid && rsp_o.rdata == 8'h00)
    else $error("unmapped data");
  a_irq_pin_pass: assert property (
    (!ien_q && $stable(ext_irq_line_four_i)) [*8] |-> irq_line_four_o == ext_irq_line_four_i)
    else $error("pin path");
  a_irq_one_pulse: assert property (ien_q && irq_line_four_o |=> !irq_line_four_o)
    else $error("irq held");
endmodule // nvc_ctrl_chk
bind nvc_ctrl nvc_ctrl_chk #(.PROG_CYCLES_P(PROG_CYCLES_P)) i_chk (.clk_i(clk_i),
  .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .req_i(req_i), .rsp_o(rsp_o),
  .ext_irq_line_four_i(ext_irq_line_four_i), .irq_line_four_o(irq_line_four_o));
`default_nettype wire

// >>> dv/nvc_ctrl_tb_top.sv
// Self-checking bench for nvc_ctrl: APB master, core model, result queues.
// Assumes the checker binds itself to the design.
`default_nettype none
module nvc_ctrl_tb_top
  import nvc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PC = 20;
  localparam logic [11:0] CA = CTRL_ADDR;
  logic        clk, rst, psel, pen, pwr, pin, rdy, err, irq;
  logic [11:0] pa;
  logic [31:0] pwd, prd, r;
  logic [3:0]  pst;
  nvc_req_t    req;
  nvc_rsp_t    rsp;
  logic [33:0] aq[$];
  logic [9:0]  dq[$];
  logic [33:0] f;
  logic [9:0]  e;
  logic [7:0]  v, b[3];
  logic [15:0] ra[3] = '{16'h002C, 16'h0021, 16'h0027};
  int          seed, err_count, check_count, n;

  nvc_ctrl #(.PROG_CYCLES_P(PC)) i_dut (.clk_i(clk), .reset_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(pst),
    .prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .req_i(req), .rsp_o(rsp),
    .ext_irq_line_four_i(pin), .irq_line_four_o(irq));
  nvc_core_model i_core (.clk_i(clk), .rsp_i(rsp), .req_o(req));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [63:0] s, input logic [63:0] x);
    check_count++;
    if (s !== x) begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, s, x);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A wait that used up its bound ends the run as a failure.
  task automatic lim(input int k, input int m);
    if (k >= m) begin
      err_count++;
      print_verdict();
    end
  endtask

  // One APB transfer; upper data and strobe bits are random.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= {24'($random(seed)), d};
    pst <= {3'($random(seed)), 1'b1};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 16);
    r = prd;
    psel <= 1'b0;
    pen <= 1'b0;
    pa <= ~a;
    pwd <= ~pwd;
    lim(k, 16);
  endtask

  task automatic rc(input logic [7:0] x);
    aq.push_back({2'b10, 24'h0, x});
    apb(1'b0, CA, 8'h00);
  endtask

  // Data access; x holds data-care, rvalid and rdata, m the edges to ack.
  task automatic dat(input logic w, wd, input logic [15:0] a, input logic [7:0] d,
                     input logic [9:0] x, input int m);
    dq.push_back(x);
    i_core.xfer(w, wd, a, d, n);
    chk(n, m);
    lim(n, 64);
  endtask

  // Poll busy, then leave the settling gap before the next array access.
  task automatic idle();
    int k;
    k = 0;
    do begin
      aq.push_back(34'h0);
      apb(1'b0, CA, 8'h00);
      k++;
    end while (r[BIT_BUSY] !== 1'b0 && k < PC);
    lim(k, PC);
    repeat (WAKE_CYCLES) @(posedge clk);
  endtask

  // Each APB read answer and each data ack takes the oldest note of its kind.
  always @(posedge clk) begin
    if (rdy === 1'b1 && pwr === 1'b0) begin
      f = aq.pop_front();
      if (f[33]) chk({err, prd}, f[32:0]);
    end
    if (rsp.ack === 1'b1) begin
      e = dq.pop_front();
      chk(rsp.rvalid, e[8]);
      if (e[9]) chk(rsp.rdata, e[7:0]);
    end
  end

  // Main sequence.
  initial begin
    seed = 32'h43132e84;
    err_count = 0;
    check_count = 0;
    {rst, psel, pen, pwr, pin, pa, pwd, pst} = {1'b1, 52'h0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rc(CTRL_RESET);
    aq.push_back({2'b11, 32'h0});
    apb(1'b0, 12'h3C0, 8'h00);
    apb(1'b1, CA, 8'h7F);
    rc(8'h75);
    apb(1'b1, CA, 8'h00);
    pin <= 1'b1;
    repeat (12) @(posedge clk);
    pin <= 1'b0;
    v = 8'($random(seed));
    dat(1, 0, {8'h02, v}, v, 10'h000, 2);
    dat(0, 0, {8'h02, v}, 0, {2'b11, v}, 2);
    dat(0, 0, {8'h03, v}, 0, 10'h200, 2);
    apb(1'b1, CA, 8'h01);
    dat(1, 0, 16'h0035, v, 10'h000, 2);
    dat(0, 0, 16'h0035, 0, 10'h2FF, 3);
    rc(8'h03);
    idle();
    dat(0, 0, 16'h0035, 0, {2'b11, v}, 3);
    dat(1, 1, 16'h0035, ~v, 10'h000, 2);
    apb(1'b1, CA, 8'h40);
    dat(1, 0, 16'h0035, ~v, 10'h000, 2);
    rc(8'h40);
    dat(0, 0, 16'h0035, 0, {2'b11, v}, 3);
    // The channel four pin stays quiet while irq enable changes, so nothing is pending.
    apb(1'b1, CA, 8'h11);
    dat(1, 0, 16'h0100, ~v, 10'h000, 2);
    n = 0;
    while (irq !== 1'b1 && n < 2 * PC) begin
      @(posedge clk);
      n++;
    end
    lim(n, 2 * PC);
    chk(irq, 1'b1);
    chk(n, PC);
    rc(8'h11);
    apb(1'b1, CA, 8'h05);
    for (int i = 0; i < 3; i++) begin
      b[i] = 8'($random(seed));
      dat(1, 0, ra[i], b[i], 10'h000, 2);
    end
    dat(1, 0, 16'h0035, ~v, 10'h000, 2);
    dat(0, 0, 16'h0021, 0, 10'h2FF, 3);
    apb(1'b1, CA, 8'h0D);
    rc(8'h0F);
    idle();
    rc(8'h01);
    for (int i = 0; i < 3; i++) dat(0, 0, ra[i], 0, {2'b11, b[i]}, 3);
    dat(0, 0, 16'h0035, 0, {2'b11, v}, 3);
    apb(1'b1, CA, 8'h09);
    rc(8'h01);
    apb(1'b1, CA, 8'h05);
    dat(1, 0, 16'h0021, ~b[1], 10'h000, 2);
    apb(1'b1, CA, 8'h01);
    dat(0, 0, 16'h0035, 0, {2'b11, v}, 3);
    apb(1'b1, CA, 8'h05);
    dat(1, 0, 16'h0022, v, 10'h000, 2);
    apb(1'b1, CA, 8'h0D);
    idle();
    dat(0, 0, 16'h0021, 0, {2'b11, b[1]}, 3);
    apb(1'b1, CA, 8'h21);
    dat(0, 0, 16'h0035, 0, 10'h2FF, 3);
    apb(1'b1, CA, 8'h01);
    dat(0, 0, 16'h0035, 0, 10'h2FF, 3);
    repeat (WAKE_CYCLES) @(posedge clk);
    dat(0, 0, 16'h0035, 0, {2'b11, v}, 3);
    // Powerdown during a programming cycle leaves the new cells weak, so only
    // the margin read can tell them apart from well-programmed ones.
    dat(1, 0, 16'h0040, v | 8'h01, 10'h000, 2);
    apb(1'b1, CA, 8'h21);
    apb(1'b1, CA, 8'h01);
    idle();
    apb(1'b1, CA, 8'h41);
    dat(0, 0, 16'h0040, 0, 10'h300, 3);
    apb(1'b1, CA, 8'h01);
    dat(0, 0, 16'h0040, 0, {2'b11, v | 8'h01}, 3);
    print_verdict();
  end
endmodule // nvc_ctrl_tb_top
`default_nettype wire

// >>> hdl/nvc_ctrl.sv
// Nonvolatile array controller: data-space decode, array and RAM storage,
// self-timed byte and row programming, control register on APB.
// Assumes the core holds each data-space request until it sees ack, and an
// APB master on the same clock; the channel four pin is asynchronous.
//
// Local design decision: the APB register port.
`default_nettype none

module nvc_ctrl
  import nvc_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Core data-space port.
  input  wire nvc_req_t    req_i,
  output nvc_rsp_t         rsp_o,
  // Channel four: external pin in, shared request out.
  input  wire logic        ext_irq_line_four_i,
  output logic             irq_line_four_o
);

  localparam int unsigned CW = $clog2(PROG_CYCLES_P + 1);

  ////////////////////////////////////////////////////////////////////////
  // Address decode helpers.

  function automatic logic is_array(input logic [15:0] a);
    return a <= ARRAY_LAST;
  endfunction

  function automatic logic is_ram(input logic [15:0] a);
    return (a >= RAM_FIRST) && (a <= RAM_LAST);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State declarations.

  logic [7:0]      ctrl_q, ctrl_d;
  nvc_prog_state_t state_q, state_d;
  logic [CW-1:0]   cnt_q, cnt_d;
  logic            single_q, single_d;
  logic [8:0]      paddr_q, paddr_d;
  logic [7:0]      pdata_q, pdata_d;
  logic            pd_seen_q, pd_seen_d;
  logic [2:0]      wake_q, wake_d;
  logic [7:0]      rbuf_q [ROW_BYTES];
  logic [15:0]     rmask_q, rmask_d;
  logic [4:0]      rrow_q, rrow_d;
  logic [7:0]      mem_q [ARRAY_BYTES];
  logic [7:0]      strong_q [ARRAY_BYTES];
  logic [7:0]      ram_q [RAM_BYTES];
  logic            dwait_q, dwait_d;
  logic            ack_q, ack_d;
  logic            rvalid_q, rvalid_d;
  logic [7:0]      rdata_q, rdata_d;
  logic            pready_q, pready_d;
  logic [31:0]     prdata_q, prdata_d;
  logic            pslverr_q, pslverr_d;
  logic            sync1_q, sync2_q, sync3_q;
  logic            ext_lvl_q, ext_lvl_d;
  logic            irq_q, irq_d;

  // Combinational event strobes.
  logic take, arr_ok, single_go, row_go, prog_done;
  logic latch_en, ram_we, apb_wr;

  ////////////////////////////////////////////////////////////////////////
  // Data-space port. A request is taken when nothing is outstanding.
  // Array reads spend one extra cycle in dwait before ack.

  always_comb begin
    take      = req_i.valid && !dwait_q && !ack_q;
    arr_ok    = !ctrl_q[BIT_BUSY] && !ctrl_q[BIT_PWRDN] && (wake_q == 3'h0);
    single_go = 1'b0;
    latch_en  = 1'b0;
    ram_we    = 1'b0;
    dwait_d   = 1'b0;
    ack_d     = dwait_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rmask_d   = rmask_q;
    rrow_d    = rrow_q;
    if (take) begin
      if (req_i.write) begin
        ack_d    = 1'b1;
        rvalid_d = 1'b0;
        rdata_d  = 8'h00;
        ram_we   = is_ram(req_i.addr);
        // Word writes and disabled writes never touch the array.
        if (is_array(req_i.addr) && !req_i.word && ctrl_q[BIT_WEN] && arr_ok) begin
          if (ctrl_q[BIT_ROW_EN]) begin
            // Bytes outside the row of the first latched byte are dropped.
            if (rmask_q == 16'h0000 || req_i.addr[8:4] == rrow_q) begin
              latch_en = 1'b1;
              rrow_d   = req_i.addr[8:4];
              rmask_d  = rmask_q | (16'h0001 << req_i.addr[3:0]);
            end
          end else begin
            single_go = 1'b1;
          end
        end
      end else if (is_array(req_i.addr)) begin
        dwait_d  = 1'b1;
        rvalid_d = arr_ok && !ctrl_q[BIT_ROW_EN];
        if (!arr_ok || ctrl_q[BIT_ROW_EN]) begin
          rdata_d = INVALID_DATA;
        end else if (ctrl_q[BIT_MARGIN]) begin
          rdata_d = mem_q[req_i.addr[8:0]] & strong_q[req_i.addr[8:0]];
        end else begin
          rdata_d = mem_q[req_i.addr[8:0]];
        end
        // A read outside row mode flushes any abandoned row.
        if (!ctrl_q[BIT_ROW_EN]) begin
          rmask_d = 16'h0000;
        end
      end else if (is_ram(req_i.addr)) begin
        ack_d    = 1'b1;
        rvalid_d = 1'b1;
        rdata_d  = ram_q[req_i.addr[7:0]];
      end else begin
        ack_d    = 1'b1;
        rvalid_d = 1'b0;
        rdata_d  = 8'h00;
      end
    end
    if (prog_done && !single_q) begin
      rmask_d = 16'h0000;
    end
  end

  // Port registers and the RAM and row buffer storage.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dwait_q  <= 1'b0;
      ack_q    <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q  <= 8'h00;
      rmask_q  <= 16'h0000;
      rrow_q   <= 5'h00;
    end else begin
      dwait_q  <= dwait_d;
      ack_q    <= ack_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rmask_q  <= rmask_d;
      rrow_q   <= rrow_d;
      if (ram_we) begin
        ram_q[req_i.addr[7:0]] <= req_i.wdata;
      end
      if (latch_en) begin
        rbuf_q[req_i.addr[3:0]] <= req_i.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Programming sequencer. The counter replaces any software delay loop.

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    single_d  = single_q;
    paddr_d   = paddr_q;
    pdata_d   = pdata_q;
    pd_seen_d = pd_seen_q || ctrl_q[BIT_PWRDN];
    prog_done = 1'b0;
    case (state_q)
      PROG_IDLE: begin
        pd_seen_d = 1'b0;
        if (single_go || row_go) begin
          state_d  = PROG_RUN;
          cnt_d    = CW'(PROG_CYCLES_P - 1);
          single_d = single_go;
          paddr_d  = req_i.addr[8:0];
          pdata_d  = req_i.wdata;
        end
      end
      PROG_RUN: begin
        if (cnt_q == '0) begin
          prog_done = 1'b1;
          state_d   = PROG_IDLE;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      default: begin
        state_d = PROG_IDLE;
      end
    endcase
  end

  // Sequencer registers. Cells are erased and rewritten at the end of the
  // cycle; powering down mid-cycle leaves the cells weak for margin reads.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q   <= PROG_IDLE;
      cnt_q     <= '0;
      single_q  <= 1'b0;
      paddr_q   <= 9'h000;
      pdata_q   <= 8'h00;
      pd_seen_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      single_q  <= single_d;
      paddr_q   <= paddr_d;
      pdata_q   <= pdata_d;
      pd_seen_q <= pd_seen_d;
      if (prog_done && single_q) begin
        mem_q[paddr_q]    <= pdata_q;
        strong_q[paddr_q] <= pd_seen_q ? 8'h00 : pdata_q;
      end
      if (prog_done && !single_q) begin
        for (int i = 0; i < ROW_BYTES; i++) begin
          if (rmask_q[i]) begin
            mem_q[{rrow_q, 4'(i)}]    <= rbuf_q[i];
            strong_q[{rrow_q, 4'(i)}] <= pd_seen_q ? 8'h00 : rbuf_q[i];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register, power-up delay and APB slave. One wait state: pready
  // rises in the second access cycle, and a write lands at the edge that ends it.

  always_comb begin
    apb_wr    = psel_i && penable_i && pready_q && pwrite_i;
    row_go    = 1'b0;
    ctrl_d    = ctrl_q;
    pready_d  = psel_i && penable_i && !pready_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (pready_d) begin
      pslverr_d = (paddr_i != CTRL_ADDR);
      prdata_d  = (paddr_i == CTRL_ADDR) ? {24'h00_0000, ctrl_q} : 32'h0000_0000;
    end
    if (apb_wr && paddr_i == CTRL_ADDR && pstrb_i[0]) begin
      // Busy is read-only and bit 7 is never written.
      ctrl_d = (ctrl_q & ~CTRL_SW_MASK) | (pwdata_i[7:0] & CTRL_SW_MASK);
      ctrl_d[BIT_ROW_START] = ctrl_q[BIT_ROW_START];
      if (ctrl_q[BIT_BUSY]) begin
        ctrl_d[BIT_ROW_EN] = ctrl_q[BIT_ROW_EN];
      end else if (pwdata_i[BIT_ROW_START] && ctrl_q[BIT_ROW_EN]) begin
        ctrl_d[BIT_ROW_START] = 1'b1;
        row_go                = 1'b1;
      end
    end
    if (single_go || row_go) begin
      ctrl_d[BIT_BUSY] = 1'b1;
    end
    if (prog_done) begin
      ctrl_d[BIT_BUSY]      = 1'b0;
      ctrl_d[BIT_ROW_EN]    = 1'b0;
      ctrl_d[BIT_ROW_START] = 1'b0;
    end
    ctrl_d[BIT_LOCKED] = 1'b0;
    if (ctrl_q[BIT_PWRDN]) begin
      wake_d = 3'(WAKE_CYCLES);
    end else if (wake_q != 3'h0) begin
      wake_d = wake_q - 3'h1;
    end else begin
      wake_d = 3'h0;
    end
  end

  // Control and APB registers.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q    <= CTRL_RESET;
      wake_q    <= 3'h0;
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      wake_q    <= wake_d;
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel four. The pin is synchronised and filtered; with irq enable
  // set the pin is cut off and the end-of-write strobe takes the channel.

  always_comb begin
    ext_lvl_d = (sync2_q == sync3_q) ? sync3_q : ext_lvl_q;
    irq_d     = ctrl_q[BIT_IRQ_EN] ? prog_done : ext_lvl_q;
  end

  // Synchroniser and channel output register.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q   <= 1'b0;
      sync2_q   <= 1'b0;
      sync3_q   <= 1'b0;
      ext_lvl_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      sync1_q   <= ext_irq_line_four_i;
      sync2_q   <= sync1_q;
      sync3_q   <= sync2_q;
      ext_lvl_q <= ext_lvl_d;
      irq_q     <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all taken straight from registers.

  assign prdata_o        = prdata_q;
  assign pready_o        = pready_q;
  assign pslverr_o       = pslverr_q;
  assign rsp_o.ack       = ack_q;
  assign rsp_o.rvalid    = rvalid_q;
  assign rsp_o.rdata     = rdata_q;
  assign irq_line_four_o = irq_q;

endmodule // nvc_ctrl

`default_nettype wire

// >>> hdl/nvc_pkg.sv
// Package for the nonvolatile array controller: register map, field
// positions, timing constants and the carrier structs of the data port.
// Assumes a single 100 MHz clock shared by the core and the controller.
`default_nettype none

package nvc_pkg;

  // Clock rate and programming time, the derived programming cycle count, and the wake delay in cycles.
  localparam int unsigned CLK_FREQ_MHZ   = 100;
  localparam int unsigned PROG_TIME_US   = 6000;
  localparam int unsigned PROG_CYCLES    = PROG_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned WAKE_CYCLES    = 6;

  // Control register: printed index and its APB byte address.
  localparam logic [7:0]  CTRL_INDEX     = 8'hF1;
  localparam logic [11:0] CTRL_ADDR      = {2'b00, CTRL_INDEX, 2'b00};
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  CTRL_SW_MASK   = 8'h7D;

  // Control register field positions.
  localparam int unsigned BIT_WEN        = 0;
  localparam int unsigned BIT_BUSY       = 1;
  localparam int unsigned BIT_ROW_EN     = 2;
  localparam int unsigned BIT_ROW_START  = 3;
  localparam int unsigned BIT_IRQ_EN     = 4;
  localparam int unsigned BIT_PWRDN      = 5;
  localparam int unsigned BIT_MARGIN     = 6;
  localparam int unsigned BIT_LOCKED     = 7;

  // Data-space map.
  localparam logic [15:0] ARRAY_LAST     = 16'h01FF;
  localparam logic [15:0] RAM_FIRST      = 16'h0200;
  localparam logic [15:0] RAM_LAST       = 16'h02FF;
  localparam int unsigned ARRAY_BYTES    = 512;
  localparam int unsigned RAM_BYTES      = 256;
  localparam int unsigned ROW_BYTES      = 16;

  // Value returned by an aborted or invalid read.
  localparam logic [7:0]  INVALID_DATA   = 8'hFF;

  // Data-space request from the core.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } nvc_req_t;

  // Data-space answer to the core.
  typedef struct packed {
    logic       ack;
    logic       rvalid;
    logic [7:0] rdata;
  } nvc_rsp_t;

  // Programming sequencer states.
  typedef enum logic {
    PROG_IDLE,
    PROG_RUN
  } nvc_prog_state_t;

endpackage

`default_nettype wire
